// File: design/fbp_flash_prot.v
`timescale 1ns/1ps
`include "fbp_regs.vh"

module fbp_flash_prot #(
  parameter ADDR_W = `FBP_ADDR_W
) (
  // Clock and reset
  input  wire                          clk_sys_i,
  input  wire                          rst_i,
  // Protection settings, two bits per unit
  input  wire [2*`FBP_NUM_UNITS-1:0]   prot_map_i,
  // Instruction fetch port
  input  wire                          ifetch_req_i,
  input  wire [ADDR_W-1:0]             ifetch_addr_i,
  output wire                          ifetch_ack_o,
  output wire                          ifetch_err_o,
  output wire [`FBP_WORD_W-1:0]        ifetch_data_o,
  // Processor data read port
  input  wire                          dread_req_i,
  input  wire [ADDR_W-1:0]             dread_addr_i,
  output wire                          dread_ack_o,
  output wire                          dread_err_o,
  output wire [`FBP_WORD_W-1:0]        dread_data_o,
  // Debugger read port
  input  wire                          dbg_req_i,
  input  wire [ADDR_W-1:0]             dbg_addr_i,
  output wire                          dbg_ack_o,
  output wire                          dbg_err_o,
  output wire [`FBP_WORD_W-1:0]        dbg_data_o,
  // Program and erase request port
  input  wire                          prog_req_i,
  input  wire [ADDR_W-1:0]             prog_addr_i,
  input  wire [`FBP_WORD_W-1:0]        prog_data_i,
  input  wire                          erase_req_i,
  input  wire [`FBP_BLK_W-1:0]         erase_blk_i,
  output wire                          wr_busy_o,
  output wire                          wr_done_o,
  output wire                          wr_refused_o
);

  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  // Sequencer states and erase length
  localparam ST_IDLE    = `FBP_ST_IDLE;
  localparam ST_ERASE   = `FBP_ST_ERASE;
  localparam ERASE_LAST = `FBP_ERASE_LAST;

  // Array contents are not reset; erase a block before reading it
  reg [`FBP_WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Sequencer registers
  reg                   st_ff;
  reg [`FBP_BLK_W-1:0]  eblk_ff;
  reg [7:0]             ecnt_ff;

  // Read answer flags, one pair per port
  reg                   if_ack_ff;
  reg                   if_err_ff;
  reg                   dr_ack_ff;
  reg                   dr_err_ff;
  reg                   db_ack_ff;
  reg                   db_err_ff;

  // Read data words, zero when no answer stands
  reg [`FBP_WORD_W-1:0] if_data_ff;
  reg [`FBP_WORD_W-1:0] dr_data_ff;
  reg [`FBP_WORD_W-1:0] db_data_ff;

  // Write result pulses
  reg                   done_ff;
  reg                   refused_ff;

  // ----------------------------------------
  // Protection lookup
  // ----------------------------------------
  // Setting codes per unit:
  //   0 - open to every access
  //   1 - read-only, all reads allowed
  //   2 - execute-only, fetches only
  //   3 - treated as read-only, so an unused code never opens the array
  // Unit index is the address bits above one 2 KB unit
  function [1:0] unit_prot;
    input [`FBP_UNIT_W-1:0] unit;
    begin
      unit_prot = prot_map_i[2*unit +: 2];
    end
  endfunction

  // Unit that each request aims at
  wire [`FBP_UNIT_W-1:0] if_unit = ifetch_addr_i[ADDR_W-1:`FBP_UNIT_LSB];
  wire [`FBP_UNIT_W-1:0] dr_unit = dread_addr_i[ADDR_W-1:`FBP_UNIT_LSB];
  wire [`FBP_UNIT_W-1:0] db_unit = dbg_addr_i[ADDR_W-1:`FBP_UNIT_LSB];
  wire [`FBP_UNIT_W-1:0] pg_unit = prog_addr_i[ADDR_W-1:`FBP_UNIT_LSB];
  wire [`FBP_UNIT_W-1:0] er_unit = erase_blk_i[`FBP_BLK_W-1:1];

  // Data reads are denied in execute-only units; fetches never are
  wire dr_deny = (unit_prot(dr_unit) == `FBP_PROT_XO);
  wire db_deny = (unit_prot(db_unit) == `FBP_PROT_XO);
  // Any protection level blocks programming and erasing
  wire pg_deny = (unit_prot(pg_unit) != `FBP_PROT_NONE);
  wire er_deny = (unit_prot(er_unit) != `FBP_PROT_NONE);

  // ----------------------------------------
  // Read ports: answer on the next edge
  // ----------------------------------------
  // Every request is answered; a denial shows only in err and data.
  // Settings are levels; a change applies to the next request.
  // Registered answers keep the array's read path out of the outputs.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      if_ack_ff  <= 1'b0;
      if_err_ff  <= 1'b0;
      dr_ack_ff  <= 1'b0;
      dr_err_ff  <= 1'b0;
      db_ack_ff  <= 1'b0;
      db_err_ff  <= 1'b0;
      if_data_ff <= `FBP_DENIED_WORD;
      dr_data_ff <= `FBP_DENIED_WORD;
      db_data_ff <= `FBP_DENIED_WORD;
    end else begin
      // Fetches are the only path into execute-only units
      if_ack_ff  <= ifetch_req_i;
      if_err_ff  <= 1'b0;
      if_data_ff <= ifetch_req_i ? mem[ifetch_addr_i] : `FBP_DENIED_WORD;
      // Processor data reads
      dr_ack_ff  <= dread_req_i;
      dr_err_ff  <= dread_req_i & dr_deny;
      // Denied reads never expose stored contents
      dr_data_ff <= (dread_req_i & ~dr_deny) ? mem[dread_addr_i]
                                             : `FBP_DENIED_WORD;
      // Debugger reads follow the same policy
      db_ack_ff  <= dbg_req_i;
      db_err_ff  <= dbg_req_i & db_deny;
      db_data_ff <= (dbg_req_i & ~db_deny) ? mem[dbg_addr_i]
                                           : `FBP_DENIED_WORD;
    end
  end

  // ----------------------------------------
  // Program and erase sequencer
  // ----------------------------------------
  // Erase sets one word per cycle to all ones; reads during erase see partial state,
  // traded for a single write port on the array.
  // Erase wins over program in one cycle; requests while busy are
  // dropped silently, so the requester must wait for busy to fall.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_ff      <= ST_IDLE;
      eblk_ff    <= {`FBP_BLK_W{1'b0}};
      ecnt_ff    <= 8'h00;
      done_ff    <= 1'b0;
      refused_ff <= 1'b0;
    end else begin
      // Result pulses last one cycle
      done_ff    <= 1'b0;
      refused_ff <= 1'b0;
      case (st_ff)
        ST_IDLE: begin
          // Erase request
          if (erase_req_i) begin
            if (er_deny) begin
              refused_ff <= 1'b1;
            end else begin
              st_ff   <= ST_ERASE;
              eblk_ff <= erase_blk_i;
              ecnt_ff <= 8'h00;
            end
          // Program request
          end else if (prog_req_i) begin
            if (pg_deny) begin
              refused_ff <= 1'b1;
            end else begin
              // Flash programming can only clear bits
              mem[prog_addr_i] <= mem[prog_addr_i] & prog_data_i;
              done_ff          <= 1'b1;
            end
          end
        end
        ST_ERASE: begin
          // One word of the latched block per cycle
          mem[{eblk_ff, ecnt_ff}] <= `FBP_ERASED_WORD;
          ecnt_ff <= ecnt_ff + 8'h01;
          // Last word written: leave busy and pulse done together
          if (ecnt_ff == ERASE_LAST) begin
            st_ff   <= ST_IDLE;
            done_ff <= 1'b1;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Read outputs
  // ----------------------------------------
  assign ifetch_ack_o  = if_ack_ff;
  assign ifetch_err_o  = if_err_ff;
  assign ifetch_data_o = if_data_ff;
  assign dread_ack_o   = dr_ack_ff;
  assign dread_err_o   = dr_err_ff;
  assign dread_data_o  = dr_data_ff;
  assign dbg_ack_o     = db_ack_ff;
  assign dbg_err_o     = db_err_ff;
  assign dbg_data_o    = db_data_ff;

  // ----------------------------------------
  // Write status outputs
  // ----------------------------------------
  // Busy is the state bit itself, so it falls with the done pulse
  assign wr_busy_o     = st_ff;
  assign wr_done_o     = done_ff;
  assign wr_refused_o  = refused_ff;

endmodule

// File: design/fbp_regs.vh
`ifndef FBP_REGS_VH
`define FBP_REGS_VH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define FBP_WORD_W        32
`define FBP_ADDR_W        14
`define FBP_BLK_W         6
`define FBP_BLK_LSB       8
`define FBP_UNIT_W        5
`define FBP_UNIT_LSB      9
`define FBP_NUM_BLKS      64
`define FBP_NUM_UNITS     32
`define FBP_WORDS_PER_BLK 256

// ----------------------------------------
// Protection encodings
// ----------------------------------------
`define FBP_PROT_NONE     2'h0
`define FBP_PROT_RO       2'h1
`define FBP_PROT_XO       2'h2

// ----------------------------------------
// Values and reset states
// ----------------------------------------
`define FBP_ERASED_WORD   32'hFFFF_FFFF
`define FBP_DENIED_WORD   32'h0000_0000
`define FBP_ST_IDLE       1'b0
`define FBP_ST_ERASE      1'b1
`define FBP_ERASE_LAST    8'hFF

`endif

// File: sim/fbp_flash_prot_asserts.sv
`timescale 1ns/1ps
`include "fbp_regs.vh"
// ----
// Port checker
// ----
module fbp_flash_prot_asserts #(parameter ADDR_W = `FBP_ADDR_W) (
  // Grouped to keep the checker short
  input wire logic                        clk_sys_i, rst_i, ifetch_req_i, ifetch_ack_o,
  input wire logic                        ifetch_err_o, dread_req_i, dread_ack_o, dread_err_o,
  input wire logic                        dbg_req_i, dbg_ack_o, dbg_err_o, prog_req_i,
  input wire logic                        erase_req_i, wr_busy_o, wr_done_o, wr_refused_o,
  input wire logic [2*`FBP_NUM_UNITS-1:0] prot_map_i,
  input wire logic [ADDR_W-1:0]           dread_addr_i, dbg_addr_i, prog_addr_i,
  input wire logic [`FBP_BLK_W-1:0]       erase_blk_i,
  input wire logic [`FBP_WORD_W-1:0]      dread_data_o, dbg_data_o
);
  // Setting of the unit each request aims at
  wire [1:0] pd = prot_map_i[2*dread_addr_i[ADDR_W-1 -: 5] +: 2];
  wire [1:0] pb = prot_map_i[2*dbg_addr_i[ADDR_W-1 -: 5] +: 2];
  wire [1:0] pp = prot_map_i[2*prog_addr_i[ADDR_W-1 -: 5] +: 2];
  wire [1:0] pe = prot_map_i[2*erase_blk_i[5:1] +: 2];
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  fetch_one_cycle_a: assert property (ifetch_req_i |=> ifetch_ack_o && !ifetch_err_o)
    else $error("fetch answer late or refused");
  dread_allowed_a: assert property (dread_req_i && pd != `FBP_PROT_XO |=> dread_ack_o && !dread_err_o)
    else $error("data read answer wrong");
  dread_deny_a: assert property (dread_req_i && pd == `FBP_PROT_XO |=> dread_err_o && dread_data_o == 0)
    else $error("data read of execute-only not denied");
  dbg_one_cycle_a: assert property (dbg_req_i |=> dbg_ack_o)
    else $error("debug answer late");
  dbg_deny_a: assert property (dbg_req_i && pb == `FBP_PROT_XO |=> dbg_err_o && dbg_data_o == 0)
    else $error("debug read of execute-only not denied");
  prog_refuse_a: assert property (prog_req_i && !erase_req_i && !wr_busy_o && pp != 0 |=> wr_refused_o && !wr_done_o)
    else $error("protected program not refused");
  erase_refuse_a: assert property (erase_req_i && !wr_busy_o && pe != 0 |=> wr_refused_o && !wr_busy_o)
    else $error("protected erase not refused");
  erase_length_a: assert property (erase_req_i && !wr_busy_o && pe == 0 |-> ##257 wr_done_o)
    else $error("erase did not finish on time");
endmodule
bind fbp_flash_prot fbp_flash_prot_asserts #(.ADDR_W(ADDR_W)) chk_u (.*);

// File: sim/fbp_req_model.sv
`timescale 1ns/1ps
// Fetch, data and debugger requesters sharing one address bus
module fbp_req_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Requests, bit 0 fetch, 1 data, 2 debugger
  output logic [2:0]       req_o,
  output logic [13:0]      addr_o
);
  initial req_o = 3'h0;
  initial addr_o = 14'h0;
  // One-cycle request; released address is inverted so stale values never match
  task automatic issue(input int p, input logic [13:0] a);
    @(posedge clk_sys_i);
    req_o <= 3'h1 << p;
    addr_o <= a;
    @(posedge clk_sys_i);
    req_o <= 3'h0;
    addr_o <= ~a;
  endtask
endmodule

// File: sim/test_flash_block_erase_protection.sv
`timescale 1ns/1ps
`include "fbp_regs.vh"
module test_flash_block_erase_protection;
  logic        clk_sys_i, rst_i, prog_req_i, erase_req_i;
  logic [63:0] prot_map_i;
  logic [13:0] prog_addr_i;
  logic [31:0] prog_data_i;
  logic [5:0]  erase_blk_i;
  wire  [2:0]  req;
  wire  [13:0] addr;
  wire         fa, fe, da, de, ba, be, busy, done, refd;
  wire  [31:0] fd, dd, bd;
  int          fails = 0, total_checks = 0, cyc = 0;
  fbp_req_model pm_u (.clk_sys_i(clk_sys_i), .req_o(req), .addr_o(addr));
  fbp_flash_prot dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .prot_map_i(prot_map_i),
    .ifetch_req_i(req[0]), .ifetch_addr_i(addr), .ifetch_ack_o(fa), .ifetch_err_o(fe),
    .ifetch_data_o(fd), .dread_req_i(req[1]), .dread_addr_i(addr), .dread_ack_o(da),
    .dread_err_o(de), .dread_data_o(dd), .dbg_req_i(req[2]), .dbg_addr_i(addr),
    .dbg_ack_o(ba), .dbg_err_o(be), .dbg_data_o(bd), .prog_req_i(prog_req_i),
    .prog_addr_i(prog_addr_i), .prog_data_i(prog_data_i), .erase_req_i(erase_req_i),
    .erase_blk_i(erase_blk_i), .wr_busy_o(busy), .wr_done_o(done), .wr_refused_o(refd));
  initial begin
    clk_sys_i = 0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Program or erase; r is {refused, done}, erase waits out its busy time
  task automatic wr(input logic er, input logic [13:0] a, input logic [31:0] d, input logic [1:0] x);
    logic [1:0] r;
    @(posedge clk_sys_i);
    erase_req_i <= er;
    prog_req_i <= !er;
    prog_addr_i <= a;
    erase_blk_i <= a[13:8];
    prog_data_i <= d;
    @(posedge clk_sys_i);
    erase_req_i <= 1'b0;
    prog_req_i <= 1'b0;
    #1 r = {refd, done};
    chk("write busy", busy, er && x == 2'h1);
    for (int i = 0; i < 300 && busy; i++) @(posedge clk_sys_i) #1 r = {refd, done};
    chk("write result", r, x);
  endtask
  // One read on port p, answer judged in the cycle it stands
  task automatic rd(input int p, input logic [13:0] a, input logic [31:0] x, input logic e);
    logic [33:0] v;
    pm_u.issue(p, a);
    #1 v = p == 0 ? {fa, fe, fd} : p == 1 ? {da, de, dd} : {ba, be, bd};
    chk("read answer", v, {1'b1, e, x});
  endtask
  task automatic sc_erase();
    wr(1, 14'h0000, 0, 1);
    wr(1, 14'h0100, 0, 1);
    wr(0, 14'h0100, 32'h1234_5678, 1);
    wr(1, 14'h0000, 0, 1);
    rd(0, 14'h0100, 32'h1234_5678, 0);
    rd(0, 14'h00ff, `FBP_ERASED_WORD, 0);
  endtask
  task automatic sc_ro();
    @(posedge clk_sys_i) prot_map_i <= 64'h1;
    wr(0, 14'h0100, 0, 2);
    wr(1, 14'h0000, 0, 2);
    wr(1, 14'h0200, 0, 1);
    rd(1, 14'h0100, 32'h1234_5678, 0);
  endtask
  task automatic sc_xo();
    @(posedge clk_sys_i) prot_map_i <= 64'h2;
    wr(0, 14'h0100, 0, 2);
    rd(0, 14'h0100, 32'h1234_5678, 0);
    rd(1, 14'h0100, `FBP_DENIED_WORD, 1);
    rd(2, 14'h0100, `FBP_DENIED_WORD, 1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Ceiling well above four erases of 257 cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    {rst_i, prog_req_i, erase_req_i, prog_addr_i, prog_data_i, erase_blk_i} = 55'h1 << 54;
    prot_map_i = 64'h0;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    sc_erase();
    sc_ro();
    sc_xo();
    tally_and_finish();
  end
endmodule
